// file: delay_select.sv
// picks the active 10-bit delay value from the stored registers
// assumes mode and register inputs are stable in the clock domain of the caller
`timescale 1ns/1ps
`default_nettype none
module delay_select (
	input  wire panel_delay_pkg::delay_regs_t regs_in,  // stored delay registers
	input  wire panel_delay_pkg::mode_sel_t   mode_in,  // mode field and centering
	output logic [9:0]                        delay_out // selected delay value
);
	always_comb
	begin
		delay_out = {regs_in.overflow[panel_delay_pkg::OVF_480_LSB +: 2], regs_in.low_480};
		case (mode_in.vsize_mode)
			panel_delay_pkg::MODE_350:
				if (mode_in.auto_center)
					delay_out = {regs_in.overflow[panel_delay_pkg::OVF_350_LSB +: 2], regs_in.low_350};
			panel_delay_pkg::MODE_400:
				if (mode_in.auto_center)
					delay_out = {regs_in.overflow[panel_delay_pkg::OVF_400_LSB +: 2], regs_in.low_400};
			panel_delay_pkg::MODE_DEF:
				delay_out = {regs_in.overflow[panel_delay_pkg::OVF_DEF_LSB +: 2], regs_in.low_def};
			default:
				delay_out = {regs_in.overflow[panel_delay_pkg::OVF_480_LSB +: 2], regs_in.low_480};
		endcase
	end
endmodule : delay_select
`default_nettype wire

// file: panel_delay_compare.sv
// panel frame-start delay compare: indexed registers and scanline compare
// assumes host i/o cycles and line strobes are synchronous to clk_in
//
// What this block does
// - The delay registers at indices 2 to 6 are reachable only while the unlock bit is one.
// - The index/data pair sits at 3B4/3B5 for the mono map and 3D4/3D5 for the color map.
// - Each delay is a 10-bit scanline count, low byte per mode and top two bits in the overflow register.
// - Mode 10 with centering enabled uses the 350-line value.
// - Mode 01 with centering enabled uses the 400-line value.
// - Mode 00 uses the default value and the panel otherwise behaves as in 480-line mode.
// - Overflow bits 7:6 are bits 9:8 of the 480-line value.
// - Overflow bits 5:4 are bits 9:8 of the 350-line value.
// - Overflow bits 3:2 are bits 9:8 of the 400-line value.
// - Overflow bits 1:0 are bits 9:8 of the default value.
// - Mode 11 uses the 480-line value.
`timescale 1ns/1ps
`default_nettype none
module panel_delay_compare (
	input  wire logic        clk_in,                // 20 mhz clock
	input  wire logic        rst_in,                // sync reset, high
	input  wire logic        ce_in,                 // clock enable
	input  wire logic [15:0] io_addr_in,            // i/o address
	input  wire logic        io_wr_in,              // i/o write strobe
	input  wire logic        io_rd_in,              // i/o read strobe
	input  wire logic [7:0]  io_wdata_in,           // i/o write data
	output logic      [7:0]  io_rdata_out,          // i/o read data
	input  wire logic        color_map_in,          // 1: color map
	input  wire logic        lcd_space_in,          // lcd timing index space selected
	input  wire logic        unlock_in,             // panel extension unlock bit
	input  wire logic        auto_center_in,        // automatic centering enable
	input  wire logic [1:0]  vsize_mode_in,         // vertical-size mode field
	input  wire logic        panel_frame_start_in,  // frame start pulse
	input  wire logic        line_strobe_in,        // one pulse per scanline
	output logic             panel_data_enable_out, // panel data may be presented
	output logic      [9:0]  scanline_out,          // scanline count since frame start
	output logic      [9:0]  delay_value_out        // active delay value
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// port pair follows the map
	function automatic logic port_hit(input logic [15:0] addr, input logic color, input logic data);
		logic [15:0] want;
		want = color ? (data ? panel_delay_pkg::DATA_PORT_COLOR : panel_delay_pkg::IDX_PORT_COLOR)
		             : (data ? panel_delay_pkg::DATA_PORT_MONO  : panel_delay_pkg::IDX_PORT_MONO);
		return addr == want;
	endfunction : port_hit

	function automatic logic [2:0] reg_slot(input logic [7:0] idx);
		logic [2:0] slot;
		slot = 3'h7;
		if (idx == panel_delay_pkg::IDX_LOW_480)
			slot = 3'h0;
		else if (idx == panel_delay_pkg::IDX_LOW_350)
			slot = 3'h1;
		else if (idx == panel_delay_pkg::IDX_LOW_400)
			slot = 3'h2;
		else if (idx == panel_delay_pkg::IDX_LOW_DEF)
			slot = 3'h3;
		else if (idx == panel_delay_pkg::IDX_OVERFLOW)
			slot = 3'h4;
		return slot;
	endfunction : reg_slot

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] index_r;
	logic [7:0] index_nxt;
	logic [7:0] regs_r   [5];
	logic [7:0] regs_nxt [5];
	logic [7:0] rdata_nxt;
	logic       idx_acc;
	logic       dat_acc;
	logic [2:0] slot;
	logic       reg_ok;

	assign idx_acc = port_hit(io_addr_in, color_map_in, 1'b0);
	assign dat_acc = port_hit(io_addr_in, color_map_in, 1'b1);
	assign slot    = reg_slot(index_r);
	// locked unless unlock bit is one
	assign reg_ok  = dat_acc && lcd_space_in && unlock_in && (slot != 3'h7);

	always_comb
	begin
		index_nxt = index_r;
		if (io_wr_in && idx_acc)
			index_nxt = io_wdata_in;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_reg
			always_comb
			begin
				regs_nxt[gi] = regs_r[gi];
				if (io_wr_in && reg_ok && (slot == 3'(gi)))
					regs_nxt[gi] = io_wdata_in;
			end
			always_ff @(posedge clk_in)
			begin
				if (rst_in)
					regs_r[gi] <= panel_delay_pkg::REG_RESET;
				else if (ce_in)
					regs_r[gi] <= regs_nxt[gi];
			end
		end
	endgenerate

	always_comb
	begin
		rdata_nxt = io_rdata_out;
		if (io_rd_in)
		begin
			rdata_nxt = 8'h00;
			if (idx_acc)
				rdata_nxt = index_r;
			else if (reg_ok)
				rdata_nxt = regs_r[slot];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			index_r      <= panel_delay_pkg::IDX_RESET;
			io_rdata_out <= 8'h00;
		end
		else if (ce_in)
		begin
			index_r      <= index_nxt;
			io_rdata_out <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// delay select and scanline compare
	// ------------------------------------------------------------
	panel_delay_pkg::delay_regs_t regs_pk;
	panel_delay_pkg::mode_sel_t   mode_pk;
	logic [9:0]                   delay_sel;
	logic [9:0]                   line_nxt;
	logic                         en_nxt;

	assign regs_pk = '{low_480: regs_r[0], low_350: regs_r[1], low_400: regs_r[2],
	                   low_def: regs_r[3], overflow: regs_r[4]};
	assign mode_pk = '{vsize_mode: vsize_mode_in, auto_center: auto_center_in};

	delay_select u_sel (
		.regs_in  (regs_pk),
		.mode_in  (mode_pk),
		.delay_out(delay_sel)
	);

	always_comb
	begin
		line_nxt = scanline_out;
		if (panel_frame_start_in)
			line_nxt = 10'h000;
		else if (line_strobe_in && (scanline_out != panel_delay_pkg::LINE_MAX))
			line_nxt = scanline_out + 10'h001;
		en_nxt = line_nxt >= delay_sel;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			scanline_out          <= 10'h000;
			delay_value_out       <= 10'h000;
			panel_data_enable_out <= 1'b0;
		end
		else if (ce_in)
		begin
			scanline_out          <= line_nxt;
			delay_value_out       <= delay_sel;
			panel_data_enable_out <= en_nxt;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence seq_locked_write;
		ce_in && io_wr_in && dat_acc && !unlock_in;
	endsequence
	sequence seq_frame;
		ce_in && panel_frame_start_in;
	endsequence

	AST_LOCKED_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
		seq_locked_write |=> (regs_r[4] == $past(regs_r[4])) && (regs_r[1] == $past(regs_r[1])))
		else $error("write landed while locked");
	AST_WRONG_MAP: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && io_wr_in && !color_map_in && (io_addr_in == panel_delay_pkg::IDX_PORT_COLOR)
		|=> index_r == $past(index_r))
		else $error("color index port decoded in mono map");
	AST_SEL_480: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && vsize_mode_in == panel_delay_pkg::MODE_480
		|=> delay_value_out == {$past(regs_r[4][7:6]), $past(regs_r[0])})
		else $error("480 value not selected");
	AST_SEL_350: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && vsize_mode_in == panel_delay_pkg::MODE_350 && auto_center_in
		|=> delay_value_out == {$past(regs_r[4][5:4]), $past(regs_r[1])})
		else $error("350 value not selected");
	AST_SEL_400: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && vsize_mode_in == panel_delay_pkg::MODE_400 && auto_center_in
		|=> delay_value_out == {$past(regs_r[4][3:2]), $past(regs_r[2])})
		else $error("400 value not selected");
	AST_SEL_DEF: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && vsize_mode_in == panel_delay_pkg::MODE_DEF
		|=> delay_value_out == {$past(regs_r[4][1:0]), $past(regs_r[3])})
		else $error("default value not selected");
	AST_FRAME_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
		seq_frame |=> scanline_out == 10'h000)
		else $error("scanline not cleared at frame start");
	AST_ENABLE_CMP: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in |=> panel_data_enable_out == (scanline_out >= delay_value_out))
		else $error("enable does not match compare");
	AST_READ_BACK: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && io_rd_in && reg_ok |=> io_rdata_out == $past(regs_r[slot]))
		else $error("read data wrong");
endmodule : panel_delay_compare
`default_nettype wire

// file: panel_delay_pkg.sv
// shared constants and carrier types for the panel frame-start delay compare block
// assumes a byte-wide indexed i/o port pair on a 16-bit i/o address
`default_nettype none
package panel_delay_pkg;
	// ------------------------------------------------------------
	// i/o ports
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_PORT_MONO  = 16'h03B4;
	localparam logic [15:0] DATA_PORT_MONO = 16'h03B5;
	localparam logic [15:0] IDX_PORT_COLOR = 16'h03D4;
	localparam logic [15:0] DATA_PORT_COLOR= 16'h03D5;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [7:0]  IDX_LOW_480    = 8'h02;
	localparam logic [7:0]  IDX_LOW_350    = 8'h03;
	localparam logic [7:0]  IDX_LOW_400    = 8'h04;
	localparam logic [7:0]  IDX_LOW_DEF    = 8'h05;
	localparam logic [7:0]  IDX_OVERFLOW   = 8'h06;
	// ------------------------------------------------------------
	// overflow field positions (low bit of each pair)
	// ------------------------------------------------------------
	localparam int          OVF_480_LSB    = 6;
	localparam int          OVF_350_LSB    = 4;
	localparam int          OVF_400_LSB    = 2;
	localparam int          OVF_DEF_LSB    = 0;
	// ------------------------------------------------------------
	// vertical-size mode codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0]  MODE_480       = 2'h3;
	localparam logic [1:0]  MODE_350       = 2'h2;
	localparam logic [1:0]  MODE_400       = 2'h1;
	localparam logic [1:0]  MODE_DEF       = 2'h0;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [7:0]  IDX_RESET      = 8'h00;
	localparam logic [9:0]  LINE_MAX       = 10'h3FF;

	typedef struct packed {
		logic [7:0] low_480;
		logic [7:0] low_350;
		logic [7:0] low_400;
		logic [7:0] low_def;
		logic [7:0] overflow;
	} delay_regs_t;

	typedef struct packed {
		logic [1:0] vsize_mode;
		logic       auto_center;
	} mode_sel_t;
endpackage : panel_delay_pkg
`default_nettype wire

// file: panel_host_model.sv
// host-side model: indexed i/o cycles plus frame-start and scanline strobes
// assumes the block samples every input on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module panel_host_model (
	input  wire logic        clk_in,                // block clock
	input  wire logic [7:0]  io_rdata_in,           // read data from block
	output logic      [15:0] io_addr_out,           // i/o address
	output logic             io_wr_out,             // write strobe
	output logic             io_rd_out,             // read strobe
	output logic      [7:0]  io_wdata_out,          // write data
	output logic             panel_frame_start_out, // frame start pulse
	output logic             line_strobe_out        // scanline pulse
);
	initial
	begin
		{io_addr_out, io_wr_out, io_rd_out, io_wdata_out} = '0;
		{panel_frame_start_out, line_strobe_out} = '0;
	end
	// released data lines show the inverse of the last value
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		{io_addr_out, io_wdata_out, io_wr_out} = {a, d, 1'b1};
		@(negedge clk_in);
		io_wr_out = 1'b0;
		io_wdata_out = ~d;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_in);
		{io_addr_out, io_rd_out} = {a, 1'b1};
		@(negedge clk_in);
		io_rd_out = 1'b0;
		@(negedge clk_in);
		d = io_rdata_in;
	endtask : rd
	// registers written first: callers load every register before any frame
	// expansion stays off: this host has no expansion request at all
	task automatic frame();
		@(negedge clk_in);
		panel_frame_start_out = 1'b1;
		@(negedge clk_in);
		panel_frame_start_out = 1'b0;
	endtask : frame
	// frame start and a scanline pulse in the same cycle
	task automatic frame_line();
		@(negedge clk_in);
		{panel_frame_start_out, line_strobe_out} = 2'b11;
		@(negedge clk_in);
		{panel_frame_start_out, line_strobe_out} = 2'b00;
	endtask : frame_line
	task automatic lines(input int n);
		repeat (n)
		begin
			@(negedge clk_in);
			line_strobe_out = 1'b1;
			@(negedge clk_in);
			line_strobe_out = 1'b0;
		end
	endtask : lines
endmodule : panel_host_model
`default_nettype wire

// file: tb.sv
// testbench: register access, mode selection and scanline compare
// assumes panel_host_model drives the i/o and strobe inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        ce = 1'b1;
	logic        color_map = 1'b1, lcd_space = 1'b1, unlock = 1'b1, auto_center = 1'b0;
	logic [1:0]  vsize_mode = 2'h3;
	logic [15:0] io_addr;
	logic        io_wr, io_rd, fs, ls, pde;
	logic [7:0]  io_wdata, rdata, v;
	logic [9:0]  scan, dval;
	int          error_cnt = 0;
	int          tests_run = 0;
	logic [7:0]  vals [5] = '{8'h02, 8'hA5, 8'h3C, 8'h7E, 8'h6C};
	always #25 clk_in = ~clk_in;
	panel_host_model host (.clk_in(clk_in), .io_rdata_in(rdata), .io_addr_out(io_addr), .io_wr_out(io_wr),
		.io_rd_out(io_rd), .io_wdata_out(io_wdata), .panel_frame_start_out(fs), .line_strobe_out(ls));
	panel_delay_compare dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .io_addr_in(io_addr),
		.io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(rdata),
		.color_map_in(color_map), .lcd_space_in(lcd_space), .unlock_in(unlock),
		.auto_center_in(auto_center), .vsize_mode_in(vsize_mode), .panel_frame_start_in(fs),
		.line_strobe_in(ls), .panel_data_enable_out(pde), .scanline_out(scan), .delay_value_out(dval));
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic [15:0] ip, input logic [7:0] idx, input logic [7:0] d, input logic w);
		host.wr(ip, idx);
		if (w)
			host.wr(ip + 16'h0001, d);
		host.rd(ip + 16'h0001, v);
	endtask : acc
	function automatic logic [9:0] exp_delay(input logic [1:0] m, input logic c);
		if (m == panel_delay_pkg::MODE_350 && c)
			return {vals[4][panel_delay_pkg::OVF_350_LSB+:2], vals[1]};
		if (m == panel_delay_pkg::MODE_400 && c)
			return {vals[4][panel_delay_pkg::OVF_400_LSB+:2], vals[2]};
		if (m == panel_delay_pkg::MODE_DEF)
			return {vals[4][panel_delay_pkg::OVF_DEF_LSB+:2], vals[3]};
		return {vals[4][panel_delay_pkg::OVF_480_LSB+:2], vals[0]};
	endfunction : exp_delay
	task automatic t_regs();
		for (int i = 0; i < 5; i++)
		begin
			acc(panel_delay_pkg::IDX_PORT_COLOR, 8'h02 + i[7:0], vals[i], 1'b1);
			chk("delay register", {2'h0, vals[i]}, {2'h0, v});
		end
		host.rd(panel_delay_pkg::IDX_PORT_COLOR, v);
		chk("index readback", {2'h0, panel_delay_pkg::IDX_OVERFLOW}, {2'h0, v});
		$display("test registers done");
	endtask : t_regs
	task automatic t_refuse();
		unlock = 1'b0;
		acc(panel_delay_pkg::IDX_PORT_COLOR, 8'h03, 8'h11, 1'b1);
		chk("locked read", 10'h000, {2'h0, v});
		unlock = 1'b1;
		lcd_space = 1'b0;
		acc(panel_delay_pkg::IDX_PORT_COLOR, 8'h03, 8'h22, 1'b1);
		chk("other space read", 10'h000, {2'h0, v});
		lcd_space = 1'b1;
		acc(panel_delay_pkg::IDX_PORT_COLOR, 8'h03, 8'h00, 1'b0);
		chk("delay_low_350_line kept", {2'h0, vals[1]}, {2'h0, v});
		color_map = 1'b0;
		acc(panel_delay_pkg::IDX_PORT_COLOR, 8'h03, 8'h33, 1'b1);
		chk("color port in mono map", 10'h000, {2'h0, v});
		acc(panel_delay_pkg::IDX_PORT_MONO, 8'h03, 8'h00, 1'b0);
		chk("mono map kept", {2'h0, vals[1]}, {2'h0, v});
		acc(panel_delay_pkg::IDX_PORT_MONO, 8'h03, 8'h5A, 1'b1);
		chk("mono map read", 10'h05A, {2'h0, v});
		acc(panel_delay_pkg::IDX_PORT_MONO, 8'h03, vals[1], 1'b1);
		color_map = 1'b1;
		$display("test refusals done");
	endtask : t_refuse
	task automatic t_modes();
		for (int i = 0; i < 8; i++)
		begin
			{vsize_mode, auto_center} = i[2:0];
			repeat (3) @(negedge clk_in);
			chk("selected delay", exp_delay(i[2:1], i[0]), dval);
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_scan();
		{vsize_mode, auto_center} = 3'b110;
		host.frame();
		@(negedge clk_in);
		chk("cleared count", 10'h000, scan);
		host.lines(int'(exp_delay(2'h3, 1'b0)) - 1);
		@(negedge clk_in);
		chk("enable before delay", 10'h000, {9'h000, pde});
		host.lines(1);
		@(negedge clk_in);
		chk("count at delay", exp_delay(2'h3, 1'b0), scan);
		chk("enable at delay", 10'h001, {9'h000, pde});
		host.frame();
		@(negedge clk_in);
		chk("enable after frame", 10'h000, {9'h000, pde});
		$display("test scanline done");
	endtask : t_scan
	task automatic t_hold();
		host.frame();
		host.lines(2);
		ce = 1'b0;
		host.lines(3);
		@(negedge clk_in);
		chk("count frozen by enable", 10'h002, scan);
		ce = 1'b1;
		host.frame_line();
		@(negedge clk_in);
		chk("frame start over strobe", 10'h000, scan);
		host.lines(1100);
		@(negedge clk_in);
		chk("count saturates", panel_delay_pkg::LINE_MAX, scan);
		$display("test hold done");
	endtask : t_hold
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		t_regs();
		t_refuse();
		t_modes();
		t_scan();
		t_hold();
		complete_run();
	end
	initial
	begin
		#(50 * 8000);
		error_cnt++;
		complete_run();
	end
endmodule : tb
`default_nettype wire
